// >>> hdl/rlpc_pkg.sv
// constants, reset values and state codes for the reset and low power controller
// assumes a single 125 MHz clock and synchronous pin inputs
// What this block does
// - supply crossing the reference starts an internal reset pulse of about 50 us
// - reset clears program counter, memory bank, register bank and stack pointer
// - reset disables interrupts, stops and clears timer, prescaler select zero, flag cleared
// - reset loads each port flip-flop with its per-bit set or reset option
// - reset leaves serial data released with flip-flop at 1, serial clock released
// - reset disables serial interface, clears its registers, pending-not bit reads 1
// - any reset cancels idle and stop modes
// - idle halts all activity except oscillator, timer and serial interface
// - an enabled interrupt ends idle, its routine runs, then execution resumes
// - with no interrupt enabled only a reset, by reset pin or power-on, ends idle, normal reset
// - stop switches the oscillator off, keeping all state and pin levels
// - stop ends on a low interrupt level or on a reset
// - stop is not entered while the interrupt pin is already low
// - after a stop wake-up by interrupt pin, execution waits 1867 cycles
// - stop wake-up: next instruction, then interrupt routine if enabled, else continue
// - derivative registers are selected by the derivative address register on derivative instructions
// - derivative interrupts share the pending line until software clears it
// - first instruction runs 1867 cycles after internal reset falls
// - pending-not bit reads 0 while serial interrupt pending, 1 otherwise
package rlpc_pkg;

	// --------------------------------------------------
	// timing
	// --------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int POR_PULSE_US = 50;
	localparam int POR_PULSE_CYCLES = POR_PULSE_US * CLK_MHZ;
	localparam int START_DELAY_CYCLES = 1866;
	localparam int DLY_W = 13;

	// --------------------------------------------------
	// reset values
	// --------------------------------------------------
	localparam logic [11:0] PC_RESET = 12'h000;
	localparam logic MEM_BANK_RESET = 1'b0;
	localparam logic REG_BANK_RESET = 1'b0;
	localparam logic [2:0] SP_RESET = 3'h0;
	localparam logic [2:0] IRQ_EN_RESET = 3'h0;
	localparam logic PRESCALER_RESET = 1'b0;
	localparam logic SDA_FF_RESET = 1'b1;
	localparam logic [7:0] SERIAL_REG_RESET = 8'h00;

	// --------------------------------------------------
	// field positions
	// --------------------------------------------------
	localparam int IRQ_EXT = 0;
	localparam int IRQ_SERIAL = 1;
	localparam int IRQ_TIMER = 2;
	localparam int STATUS_PENDING_N_BIT = 7;
	localparam int STATUS_ENABLE_BIT = 6;

	// serial register select codes
	localparam logic [1:0] SER_SHIFT = 2'h0;
	localparam logic [1:0] SER_OWN_ADDR = 2'h1;
	localparam logic [1:0] SER_STATUS = 2'h2;
	localparam logic [1:0] SER_CLK_CTRL = 2'h3;

	// derivative instruction codes
	localparam logic [1:0] DOP_MOV_IN = 2'h0;
	localparam logic [1:0] DOP_MOV_OUT = 2'h1;
	localparam logic [1:0] DOP_ANL = 2'h2;
	localparam logic [1:0] DOP_ORL = 2'h3;

	typedef enum logic [5:0] {
		ST_RESET = 6'h01,
		ST_START = 6'h02,
		ST_RUN = 6'h04,
		ST_IDLE = 6'h08,
		ST_STOP = 6'h10,
		ST_WAKE = 6'h20
	} rlpc_state_t;

endpackage

// >>> hdl/rlpc_delay.sv
// down counter that times one delay from a start pulse
// assumes start is not raised while a delay is running
`timescale 1ns/1ps
module rlpc_delay #(
	parameter int W = 13
) (
	input wire logic clock, // system clock
	input wire logic rst_n, // synchronised reset, active low
	input wire logic start, // one-cycle start pulse
	input wire logic [W-1:0] load, // delay length in cycles
	output logic busy, // high while counting
	output logic done // one-cycle pulse at the end
);
	logic [W-1:0] cnt;

	assign busy = (cnt != '0);

	// load on start, count down to zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			done <= 1'b0;
		end else begin
			done <= (cnt == W'(1));
			if (start)
				cnt <= load;
			else if (busy)
				cnt <= cnt - W'(1);
		end
	end
endmodule // rlpc_delay

// >>> hdl/rlpc_top.sv
// reset sequencing, idle and stop control, reset state of timer, ports and serial interface, derivative register access
// assumes all pin inputs are synchronous to clock; the oscillator gate is osc_enable
`timescale 1ns/1ps
module rlpc_top #(
	parameter int POR_CYCLES = rlpc_pkg::POR_PULSE_CYCLES, // power-on pulse length
	parameter int PORT_W = 8, // port flip-flops besides serial data
	parameter logic [PORT_W-1:0] PORT_SET_OPTION = '1, // 1 = set option per bit
	parameter int DERIV_AW = 2, // derivative address width
	parameter logic [(1<<DERIV_AW)-1:0] DERIV_READABLE = '1, // readable derivative registers
	parameter logic [(1<<DERIV_AW)-1:0] DERIV_WRITABLE = '1 // writable derivative registers
) (
	input wire logic clock, // system clock
	input wire logic nrst, // asynchronous reset, active low
	input wire logic supply_above_ref, // supply above power-on reference
	input wire logic reset_pin, // external reset pin, active high
	input wire logic ext_irq_n_pin, // external interrupt pin, active low
	input wire logic idle_exec, // idle instruction executed
	input wire logic stop_exec, // stop instruction executed
	input wire logic timer_irq, // timer overflow event
	input wire logic serial_event, // serial interface interrupt event
	input wire logic deriv_irq, // derivative interrupt event
	input wire logic irq_en_wr, // write interrupt enables
	input wire logic [2:0] irq_en_wdata, // enables: timer, serial, external
	input wire logic timer_ctl_wr, // write timer run and prescaler
	input wire logic timer_run_wdata, // timer run
	input wire logic prescaler_wdata, // prescaler select
	input wire logic timer_flag_clr, // software clears timer flag
	input wire logic port_wr, // write port flip-flops
	input wire logic [PORT_W-1:0] port_wdata, // port data
	input wire logic sda_wr, // write serial data flip-flop
	input wire logic sda_wdata, // serial data flip-flop value
	input wire logic serial_wr, // write serial register
	input wire logic [1:0] serial_sel, // serial register select
	input wire logic [7:0] serial_wdata, // serial write data
	input wire logic deriv_addr_wr, // write derivative address
	input wire logic [DERIV_AW-1:0] deriv_addr_wdata, // derivative address
	input wire logic deriv_exec, // derivative instruction executes
	input wire logic [1:0] deriv_op, // derivative instruction kind
	input wire logic [7:0] acc_data, // accumulator value
	input wire logic [7:0] deriv_rdata, // data from selected derivative register
	output logic internal_reset, // internal reset, active high
	output logic cpu_run, // core may execute
	output logic core_clk_en, // core clock gate
	output logic periph_clk_en, // timer and serial clock gate
	output logic osc_enable, // oscillator runs
	output logic irq_grant, // enabled interrupt taken to end idle
	output logic ext_irq_after_next, // external interrupt after next instruction
	output logic [11:0] program_counter, // program counter load value
	output logic memory_bank, // memory bank
	output logic register_bank, // register bank
	output logic [2:0] stack_pointer, // stack pointer
	output logic [2:0] irq_enable, // interrupt enables
	output logic timer_run, // timer running
	output logic timer_clear, // timer counter clear
	output logic prescaler_select, // 0 = modulo-32
	output logic timer_flag, // timer flag
	output logic [PORT_W-1:0] port_ff, // port flip-flops
	output logic serial_data_port_pin_o, // serial data output level
	output logic serial_data_port_pin_oe, // serial data drive enable
	output logic serial_clock_o, // serial clock output level
	output logic serial_clock_oe, // serial clock drive enable
	output logic serial_enable_bit, // serial interface enabled
	output logic [7:0] serial_shift_reg, // serial data register
	output logic [7:0] own_address_reg, // own address register
	output logic [7:0] serial_status_reg, // status with pending-not
	output logic [7:0] serial_clock_ctrl_reg, // clock control register
	output logic [(1<<DERIV_AW)-1:0] derivative_reg_select, // one-hot derivative select
	output logic deriv_rd, // derivative read strobe
	output logic deriv_wr, // derivative write strobe
	output logic [7:0] deriv_wdata, // derivative write data
	output logic [7:0] acc_result // accumulator result of a derivative read
);
	// --------------------------------------------------
	// reset release and power-on pulse
	// --------------------------------------------------
	logic rst_meta, rst_n, supply_q, ext_q, por_busy, dly_done, dly_busy, pending;
	logic [DERIV_AW-1:0] deriv_addr;
	rlpc_pkg::rlpc_state_t state, next_state;

	// two-stage release of the asynchronous reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	wire por_rise = supply_above_ref & ~supply_q;
	wire next_reset = reset_pin | por_busy | por_rise;

	rlpc_delay #(.W(rlpc_pkg::DLY_W)) u_por (
		.clock(clock),
		.rst_n(rst_n),
		.start(por_rise),
		.load(rlpc_pkg::DLY_W'(POR_CYCLES)),
		.busy(por_busy),
		.done()
	);

	// edge memory and the internal reset flop
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			supply_q <= 1'b0;
			ext_q <= 1'b1;
			internal_reset <= 1'b1;
		end else begin
			supply_q <= supply_above_ref;
			ext_q <= ext_irq_n_pin;
			internal_reset <= next_reset;
		end
	end

	// --------------------------------------------------
	// power mode sequencer
	// --------------------------------------------------
	wire ext_fall = ext_q & ~ext_irq_n_pin;
	wire [2:0] irq_events = {timer_irq, pending, ext_fall};
	wire idle_wake = |(irq_events & irq_enable);
	wire stop_entry = stop_exec & ext_irq_n_pin;
	wire stop_wake = ~ext_irq_n_pin;
	wire dly_start = ((state == rlpc_pkg::ST_RESET) & ~next_reset) | ((state == rlpc_pkg::ST_STOP) & stop_wake);

	rlpc_delay #(.W(rlpc_pkg::DLY_W)) u_start (
		.clock(clock),
		.rst_n(rst_n),
		.start(dly_start),
		.load(rlpc_pkg::DLY_W'(rlpc_pkg::START_DELAY_CYCLES)),
		.busy(dly_busy),
		.done(dly_done)
	);

	// next state, reset has priority over every mode
	always_comb begin
		next_state = state;
		unique case (state)
			rlpc_pkg::ST_RESET: if (!next_reset) next_state = rlpc_pkg::ST_START;
			rlpc_pkg::ST_START: if (dly_done) next_state = rlpc_pkg::ST_RUN;
			rlpc_pkg::ST_RUN: begin
				if (idle_exec)
					next_state = rlpc_pkg::ST_IDLE;
				else if (stop_entry)
					next_state = rlpc_pkg::ST_STOP;
			end
			rlpc_pkg::ST_IDLE: if (idle_wake) next_state = rlpc_pkg::ST_RUN;
			rlpc_pkg::ST_STOP: if (stop_wake) next_state = rlpc_pkg::ST_WAKE;
			rlpc_pkg::ST_WAKE: if (dly_done) next_state = rlpc_pkg::ST_RUN;
		endcase
		if (next_reset)
			next_state = rlpc_pkg::ST_RESET;
	end

	// state and the two wake-up pulses
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= rlpc_pkg::ST_RESET;
			irq_grant <= 1'b0;
			ext_irq_after_next <= 1'b0;
		end else begin
			state <= next_state;
			irq_grant <= (state == rlpc_pkg::ST_IDLE) & idle_wake & ~next_reset;
			ext_irq_after_next <= (state == rlpc_pkg::ST_WAKE) & dly_done & ~next_reset
				& irq_enable[rlpc_pkg::IRQ_EXT];
		end
	end

	// activity gates per mode
	assign cpu_run = (state == rlpc_pkg::ST_RUN);
	assign core_clk_en = (state == rlpc_pkg::ST_RUN) | (state == rlpc_pkg::ST_START) | (state == rlpc_pkg::ST_RESET);
	assign periph_clk_en = core_clk_en | (state == rlpc_pkg::ST_IDLE);
	assign osc_enable = (state != rlpc_pkg::ST_STOP);

	// --------------------------------------------------
	// core, timer and port reset state
	// --------------------------------------------------
	assign timer_clear = internal_reset;

	// core values are constants loaded on reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			program_counter <= rlpc_pkg::PC_RESET;
			memory_bank <= rlpc_pkg::MEM_BANK_RESET;
			register_bank <= rlpc_pkg::REG_BANK_RESET;
			stack_pointer <= rlpc_pkg::SP_RESET;
		end else if (internal_reset) begin
			program_counter <= rlpc_pkg::PC_RESET;
			memory_bank <= rlpc_pkg::MEM_BANK_RESET;
			register_bank <= rlpc_pkg::REG_BANK_RESET;
			stack_pointer <= rlpc_pkg::SP_RESET;
		end
	end

	// interrupt enables and timer control; stop keeps them untouched
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable <= rlpc_pkg::IRQ_EN_RESET;
			timer_run <= 1'b0;
			prescaler_select <= rlpc_pkg::PRESCALER_RESET;
			timer_flag <= 1'b0;
		end else if (internal_reset) begin
			irq_enable <= rlpc_pkg::IRQ_EN_RESET;
			timer_run <= 1'b0;
			prescaler_select <= rlpc_pkg::PRESCALER_RESET;
			timer_flag <= 1'b0;
		end else begin
			if (irq_en_wr)
				irq_enable <= irq_en_wdata;
			if (timer_ctl_wr) begin
				timer_run <= timer_run_wdata;
				prescaler_select <= prescaler_wdata;
			end
			timer_flag <= timer_irq | (timer_flag & ~timer_flag_clr); // set wins
		end
	end

	// port flip-flops, one per bit with its own option
	genvar gi;
	generate
		for (gi = 0; gi < PORT_W; gi++) begin : g_port
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n)
					port_ff[gi] <= PORT_SET_OPTION[gi];
				else if (internal_reset)
					port_ff[gi] <= PORT_SET_OPTION[gi];
				else if (port_wr)
					port_ff[gi] <= port_wdata[gi];
			end
		end
	endgenerate

	// --------------------------------------------------
	// serial interface reset state and pending line
	// --------------------------------------------------
	logic sda_ff;
	logic [6:0] status_low; // stored status bits below the pending-not bit
	wire set_pending = serial_event | deriv_irq;
	wire clr_pending = serial_wr & (serial_sel == rlpc_pkg::SER_STATUS) & serial_wdata[rlpc_pkg::STATUS_PENDING_N_BIT];

	// open drain pins are released unless pulled low
	assign serial_data_port_pin_o = 1'b0;
	assign serial_data_port_pin_oe = ~sda_ff;
	assign serial_clock_o = 1'b0;
	assign serial_clock_oe = serial_enable_bit & pending;
	assign serial_status_reg = {~pending, status_low};

	// serial registers, the pending line and the data flip-flop
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sda_ff <= rlpc_pkg::SDA_FF_RESET;
			pending <= 1'b0;
			serial_enable_bit <= 1'b0;
			serial_shift_reg <= rlpc_pkg::SERIAL_REG_RESET;
			own_address_reg <= rlpc_pkg::SERIAL_REG_RESET;
			status_low <= 7'h00;
			serial_clock_ctrl_reg <= rlpc_pkg::SERIAL_REG_RESET;
		end else if (internal_reset) begin
			sda_ff <= rlpc_pkg::SDA_FF_RESET;
			pending <= 1'b0;
			serial_enable_bit <= 1'b0;
			serial_shift_reg <= rlpc_pkg::SERIAL_REG_RESET;
			own_address_reg <= rlpc_pkg::SERIAL_REG_RESET;
			status_low <= 7'h00;
			serial_clock_ctrl_reg <= rlpc_pkg::SERIAL_REG_RESET;
		end else begin
			if (sda_wr)
				sda_ff <= sda_wdata;
			pending <= set_pending | (pending & ~clr_pending);
			if (serial_wr) begin
				unique case (serial_sel)
					rlpc_pkg::SER_SHIFT: if (serial_enable_bit) serial_shift_reg <= serial_wdata;
					rlpc_pkg::SER_OWN_ADDR: if (!serial_enable_bit) own_address_reg <= serial_wdata;
					rlpc_pkg::SER_STATUS: begin
						serial_enable_bit <= serial_wdata[rlpc_pkg::STATUS_ENABLE_BIT];
						status_low <= serial_wdata[6:0];
					end
					rlpc_pkg::SER_CLK_CTRL: serial_clock_ctrl_reg <= serial_wdata;
				endcase
			end
		end
	end

	// --------------------------------------------------
	// derivative register access
	// --------------------------------------------------
	wire sel_readable = DERIV_READABLE[deriv_addr];
	wire sel_writable = DERIV_WRITABLE[deriv_addr];
	wire [7:0] deriv_view = sel_readable ? deriv_rdata : 8'h00;
	wire op_reads = (deriv_op != rlpc_pkg::DOP_MOV_OUT);
	wire op_writes = (deriv_op != rlpc_pkg::DOP_MOV_IN);
	wire [7:0] next_wdata = (deriv_op == rlpc_pkg::DOP_ANL) ? (deriv_view & acc_data) :
		(deriv_op == rlpc_pkg::DOP_ORL) ? (deriv_view | acc_data) : acc_data;

	// one-hot select from the derivative address
	generate
		for (gi = 0; gi < (1 << DERIV_AW); gi++) begin : g_dsel
			assign derivative_reg_select[gi] = (deriv_addr == DERIV_AW'(gi));
		end
	endgenerate

	// address register and registered access strobes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			deriv_addr <= '0;
			deriv_rd <= 1'b0;
			deriv_wr <= 1'b0;
			deriv_wdata <= 8'h00;
			acc_result <= 8'h00;
		end else begin
			if (deriv_addr_wr)
				deriv_addr <= deriv_addr_wdata;
			deriv_rd <= deriv_exec & op_reads & sel_readable & cpu_run;
			deriv_wr <= deriv_exec & op_writes & sel_writable & cpu_run;
			if (deriv_exec & op_writes)
				deriv_wdata <= next_wdata;
			if (deriv_exec & (deriv_op == rlpc_pkg::DOP_MOV_IN))
				acc_result <= deriv_view;
		end
	end

	// --------------------------------------------------
	// checks
	// --------------------------------------------------
	logic [12:0] run_gap;
	// cycles since internal reset fell, for the start delay check
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			run_gap <= '0;
		else if (internal_reset)
			run_gap <= '0;
		else if (!cpu_run && run_gap != 13'h1fff)
			run_gap <= run_gap + 13'h0001;
	end

	start_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(cpu_run) && $past(state) == rlpc_pkg::ST_START |-> run_gap == 13'h074b)
		else $error("start delay wrong");
	reset_cancel_a: assert property (@(posedge clock) disable iff (!rst_n)
		reset_pin |=> state == rlpc_pkg::ST_RESET && !cpu_run)
		else $error("reset did not cancel mode");
	por_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
		por_rise |=> internal_reset [*8])
		else $error("power-on pulse too short");
	stop_block_a: assert property (@(posedge clock) disable iff (!rst_n)
		state == rlpc_pkg::ST_RUN && stop_exec && !ext_irq_n_pin && !idle_exec && !next_reset
		|=> state == rlpc_pkg::ST_RUN)
		else $error("stop entered with pin low");
	osc_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
		state == rlpc_pkg::ST_STOP && ext_irq_n_pin && !next_reset |=> !osc_enable && $stable(port_ff))
		else $error("stop did not hold state");
	stop_wake_a: assert property (@(posedge clock) disable iff (!rst_n)
		state == rlpc_pkg::ST_STOP && !ext_irq_n_pin && !next_reset
		|=> state == rlpc_pkg::ST_WAKE ##1 !cpu_run [*8])
		else $error("stop wake wrong");
	idle_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		state == rlpc_pkg::ST_IDLE |-> !core_clk_en && periph_clk_en && osc_enable)
		else $error("idle gating wrong");
	idle_wake_a: assert property (@(posedge clock) disable iff (!rst_n)
		state == rlpc_pkg::ST_IDLE && !next_reset && (irq_events & irq_enable) != 3'h0
		|=> irq_grant && cpu_run)
		else $error("idle not left on interrupt");
	idle_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		state == rlpc_pkg::ST_IDLE && irq_enable == 3'h0 && !next_reset |=> state == rlpc_pkg::ST_IDLE)
		else $error("idle left without interrupt");
	pending_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		set_pending && !internal_reset |=> !serial_status_reg[rlpc_pkg::STATUS_PENDING_N_BIT])
		else $error("pending lost");
	reset_values_a: assert property (@(posedge clock) disable iff (!rst_n)
		internal_reset |=> irq_enable == 3'h0 && !timer_run && !serial_enable_bit && sda_ff
		&& port_ff == PORT_SET_OPTION && serial_status_reg[rlpc_pkg::STATUS_PENDING_N_BIT])
		else $error("reset values wrong");
endmodule // rlpc_top

// >>> testbench/rlpc_ext_src.sv
// model of the external reset and interrupt sources at the controller pins
// assumes the bench calls its tasks from the clock domain
`timescale 1ns/1ps
module rlpc_ext_src (
	input wire logic clock, // system clock
	output logic reset_pin, // active reset drive
	output logic ext_irq_n_pin // interrupt line, active low
);
	// idle levels: reset released, interrupt line high
	initial begin
		reset_pin = 1'b0;
		ext_irq_n_pin = 1'b1;
	end
	// active reset held high for n clock edges, then released
	task automatic pulse_reset(input int n);
		@(posedge clock);
		reset_pin <= 1'b1;
		repeat (n) @(posedge clock);
		reset_pin <= 1'b0;
	endtask
	// drives the interrupt line to the given level at the next clock edge
	task automatic irq_level(input logic v);
		@(posedge clock);
		ext_irq_n_pin <= v;
	endtask
endmodule // rlpc_ext_src

// >>> testbench/test_reset_and_low_power_control.sv
// self-checking bench for the reset and low power controller
// assumes the source model drives the reset and interrupt pins
`timescale 1ns/1ps
module test_reset_and_low_power_control;
	localparam logic [7:0] PORT_OPT = 8'h5a;
	logic clock = 1'b0, nrst = 1'b0, supply_above_ref = 1'b0, irq_en_wr = 1'b0, serial_wr = 1'b0, deriv_exec = 1'b0;
	logic idle_exec = 1'b0, stop_exec = 1'b0, timer_irq = 1'b0, serial_event = 1'b0, deriv_irq = 1'b0, z = 1'b0;
	logic [2:0] irq_en_wdata = 3'h0, stack_pointer, irq_enable;
	logic [1:0] serial_sel = 2'h2, deriv_op = 2'h0;
	logic [7:0] serial_wdata = 8'h00, acc_data = 8'h00, deriv_rdata = 8'h00, port_ff, deriv_wdata, acc_result;
	logic [7:0] serial_shift_reg, own_address_reg, serial_status_reg, serial_clock_ctrl_reg;
	logic [11:0] program_counter;
	logic internal_reset, cpu_run, core_clk_en, periph_clk_en, osc_enable, irq_grant, ext_irq_after_next, memory_bank;
	logic register_bank, timer_run, timer_clear, prescaler_select, timer_flag, serial_enable_bit;
	logic serial_data_port_pin_oe, serial_clock_oe, reset_pin, ext_irq_n_pin;
	logic timer_ctl_wr = 1'b0, timer_run_wdata = 1'b0, prescaler_wdata = 1'b0, port_wr = 1'b0, sda_wr = 1'b0;
	logic sda_wdata = 1'b0, serial_data_port_pin_o, serial_clock_o, deriv_rd, deriv_wr;
	logic [7:0] port_wdata = 8'h00;
	logic [3:0] derivative_reg_select;
	// derivative rows: op, accumulator, register data, expected read and write strobes, expected result
	logic [27:0] rows [4] = '{{2'h0, 8'h12, 8'h3c, 2'h2, 8'h3c}, {2'h1, 8'ha5, 8'hff, 2'h1, 8'ha5},
		{2'h2, 8'hf0, 8'h3c, 2'h3, 8'h30}, {2'h3, 8'h0f, 8'h30, 2'h3, 8'h3f}};
	int n_errors = 0, num_checks = 0, n;

	rlpc_top #(.POR_CYCLES(20), .PORT_SET_OPTION(PORT_OPT)) i_dut (.*, .timer_flag_clr(z), .deriv_addr_wr(z),
		.deriv_addr_wdata(2'h0));
	rlpc_ext_src i_src (.clock(clock), .reset_pin(reset_pin), .ext_irq_n_pin(ext_irq_n_pin));

	// free-running 125 MHz clock
	initial forever #4 clock = ~clock;

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one-cycle pulses on idle, stop, timer, serial and derivative inputs
	task automatic cmd(input logic [4:0] p);
		@(posedge clock);
		{idle_exec, stop_exec, timer_irq, serial_event, deriv_irq} <= p;
		@(posedge clock);
		{idle_exec, stop_exec, timer_irq, serial_event, deriv_irq} <= 5'h00;
		#1;
	endtask
	// interrupt enable write and serial status write
	task automatic wr(input logic [1:0] k, input logic [7:0] d);
		@(posedge clock);
		{irq_en_wr, serial_wr} <= k;
		irq_en_wdata <= d[2:0];
		serial_wdata <= d;
		@(posedge clock);
		{irq_en_wr, serial_wr} <= 2'b00;
		#1;
	endtask
	// counts edges until the core may run, bounded
	task automatic count_run(input logic [39:0] exp);
		for (n = 1; n < 3000; n++) begin
			@(posedge clock);
			#1;
			if (cpu_run === 1'b1)
				break;
		end
		check(40'(n), exp);
		if (n >= 3000)
			summarize();
	endtask
	// waits for the internal reset to fall, then times the start-up delay
	task automatic wait_start();
		for (n = 0; n < 200 && internal_reset !== 1'b0; n++) begin
			@(posedge clock);
			#1;
		end
		check(internal_reset, 40'h0);
		count_run(40'h74b);
	endtask

	initial begin
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		supply_above_ref <= 1'b1;
		repeat (10) @(posedge clock);
		#1;
		check({internal_reset, timer_clear, cpu_run}, 40'h6);
		wait_start();
		check({program_counter, memory_bank, register_bank, stack_pointer, irq_enable, timer_run, prescaler_select,
			timer_flag}, 40'h0);
		check({port_ff, serial_data_port_pin_oe, serial_clock_oe, serial_data_port_pin_o, serial_clock_o,
			derivative_reg_select}, {PORT_OPT, 4'h0, 4'h1});
		check({serial_enable_bit, serial_shift_reg, own_address_reg, serial_status_reg, serial_clock_ctrl_reg},
			40'h8000);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			{deriv_op, acc_data, deriv_rdata} <= rows[i][27:10];
			deriv_exec <= 1'b1;
			@(posedge clock);
			deriv_exec <= 1'b0;
			#1;
			check(rows[i][27:26] == 2'h0 ? acc_result : deriv_wdata, rows[i][7:0]);
			check({deriv_rd, deriv_wr}, rows[i][9:8]);
		end
		$display("test derivative done");
		wr(2'b10, 8'h04);
		cmd(5'h10);
		check({cpu_run, core_clk_en, periph_clk_en, osc_enable}, 40'h3);
		cmd(5'h04);
		for (n = 0; n < 4 && irq_grant !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		check({irq_grant, cpu_run}, 40'h3);
		$display("test idle done");
		cmd(5'h01);
		check(serial_status_reg[7], 40'h0);
		wr(2'b01, 8'hc0);
		check({serial_enable_bit, serial_status_reg}, {1'b1, 8'hc0});
		cmd(5'h02);
		check({serial_status_reg[7], serial_clock_oe}, 40'h1);
		$display("test pending done");
		i_src.irq_level(1'b0);
		cmd(5'h08);
		check({osc_enable, cpu_run}, 40'h3);
		i_src.irq_level(1'b1);
		wr(2'b10, 8'h01);
		cmd(5'h08);
		check({osc_enable, cpu_run, port_ff}, {2'b00, PORT_OPT});
		i_src.irq_level(1'b0);
		// the line is sampled low one edge after the model drives it, so one edge more than from reset
		count_run(40'h74c);
		check(ext_irq_after_next, 40'h1);
		i_src.irq_level(1'b1);
		$display("test stop done");
		// idle entered with the line already low needs a high then a fresh low to wake
		i_src.irq_level(1'b0);
		cmd(5'h10);
		check(cpu_run, 40'h0);
		i_src.irq_level(1'b1);
		i_src.irq_level(1'b0);
		@(posedge clock);
		#1;
		check({irq_grant, cpu_run}, 40'h3);
		i_src.irq_level(1'b1);
		$display("test idle edge done");
		// move timer, port and serial data flip-flop away from their reset values
		@(posedge clock);
		{timer_ctl_wr, timer_run_wdata, prescaler_wdata, port_wr, sda_wr, sda_wdata} <= 6'h3e;
		port_wdata <= 8'ha5;
		@(posedge clock);
		{timer_ctl_wr, port_wr, sda_wr} <= 3'h0;
		#1;
		check({timer_run, prescaler_select, timer_flag, port_ff, serial_data_port_pin_oe, serial_clock_oe},
			{3'h7, 8'ha5, 2'h3});
		cmd(5'h08);
		i_src.pulse_reset(4);
		wait_start();
		check({timer_run, prescaler_select, timer_flag, irq_enable, port_ff, serial_data_port_pin_oe, serial_clock_oe},
			{6'h00, PORT_OPT, 2'h0});
		wr(2'b10, 8'h00);
		cmd(5'h10);
		cmd(5'h04);
		check(cpu_run, 40'h0);
		i_src.pulse_reset(4);
		wait_start();
		$display("test reset exits done");
		summarize();
	end
endmodule // test_reset_and_low_power_control
